//--- src/interrupt_wake_controller.sv
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "irq_wake_consts.svh"

module interrupt_wake_controller #(
    parameter int unsigned IRQ_DELAY_CYC = `IRQ_DELAY_CYC
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire irq_wake_pkg::bus_req_t bus_i,
    output logic [31:0] rdata_o,
    input wire logic [`NUM_SRC-1:0] event_i,
    input wire logic watchdog_overflow_i,
    input wire logic can_rx_i,
    input wire logic lin_a_rx_i,
    input wire logic lin_b_rx_i,
    output var irq_wake_pkg::od_pin_t irq_out_primary_n_o,
    output var irq_wake_pkg::od_pin_t irq_out_priority_n_o,
    output logic can_rx_out_o,
    output logic lin_a_rx_out_o,
    output logic lin_b_rx_out_o,
    output logic chip_reset_out_n_o,
    output var irq_wake_pkg::op_mode_t op_mode_o
);

    // ------------------------------------------------------------
    // Register access decode
    // ------------------------------------------------------------
    logic [`NUM_SRC-1:0] status;
    logic [`NUM_SRC-1:0] enable;
    logic [`NUM_SRC-1:0] eff_enable;
    logic [`NUM_SRC-1:0] clear_bits;
    logic [`NUM_SRC-1:0] set_bits;
    logic [4:0] global_status;
    logic wr_status;
    logic wr_enable;
    logic wr_mode;
    logic sleep_cmd;
    logic pending_any;
    logic wd_again;
    logic [31:0] delay_cnt;
    logic timer_run;
    logic [7:0] hold_cnt;
    irq_wake_pkg::op_mode_t mode;
    irq_wake_pkg::op_mode_t next_mode;

    // Write strobes for the status, enable and mode registers.
    assign wr_status = bus_i.wr && (bus_i.addr == `ADDR_STATUS);
    assign wr_enable = bus_i.wr && (bus_i.addr == `ADDR_ENABLE);
    assign wr_mode = bus_i.wr && (bus_i.addr == `ADDR_MODE);
    assign sleep_cmd = wr_mode && (bus_i.wdata[2:0] == `MODE_CMD_SLEEP);

    // Permanently enabled sources ignore their enable bits.
    assign eff_enable = enable | `ALWAYS_ON_MASK;

    // Events of enabled sources, bus and local wake-ups included.
    assign set_bits = event_i & eff_enable;
    // Only bits actually pending count as cleared.
    assign clear_bits = wr_status ? (bus_i.wdata[`NUM_SRC-1:0] & status) : '0;
    assign pending_any = |status;

    // A second watchdog overflow while its flag is still pending.
    assign wd_again = watchdog_overflow_i && status[`SRC_WATCHDOG];

    // ------------------------------------------------------------
    // Pending status and enables
    // ------------------------------------------------------------
    // Set wins over a clear in the same cycle; bits stay until cleared.
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            status <= '0;
        end else begin
            status <= (status & ~clear_bits) | set_bits;
        end
    end

    // Enable register written by software.
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            enable <= `ENABLE_RESET;
        end else if (wr_enable) begin
            enable <= bus_i.wdata[`NUM_SRC-1:0];
        end
    end

    // Category summary of pending bits.
    assign global_status[0] = |(status & `CAT_SYSTEM_MASK);
    assign global_status[1] = |(status & `CAT_SUPPLY_MASK);
    assign global_status[2] = |(status & `CAT_XCVR_MASK);
    assign global_status[3] = |(status & `CAT_BANK0_MASK);
    assign global_status[4] = |(status & `CAT_BANK1_MASK);

    // Read data one cycle after the read strobe; unmapped reads as zero.
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_o <= '0;
        end else if (bus_i.rd) begin
            case (bus_i.addr)
                `ADDR_STATUS: rdata_o <= {11'h000, status};
                `ADDR_ENABLE: rdata_o <= {11'h000, eff_enable};
                `ADDR_GLOBAL: rdata_o <= {27'h0000000, global_status};
                `ADDR_MODE: rdata_o <= {29'h00000000, mode};
                default: rdata_o <= '0;
            endcase
        end else begin
            rdata_o <= '0;
        end
    end

    // ------------------------------------------------------------
    // Interrupt delay timer
    // ------------------------------------------------------------
    // Restarts on any clear, stops at once while chip reset is low.
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            delay_cnt <= '0;
        end else if (!chip_reset_out_n_o) begin
            delay_cnt <= '0;
        end else if (|clear_bits) begin
            delay_cnt <= IRQ_DELAY_CYC;
        end else if (delay_cnt != '0) begin
            delay_cnt <= delay_cnt - 32'h00000001;
        end
    end
    assign timer_run = (delay_cnt != '0);

    // ------------------------------------------------------------
    // Request outputs
    // ------------------------------------------------------------
    // Pins only ever pull low; released means enable off.
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_out_primary_n_o <= '0;
            irq_out_priority_n_o <= '0;
        end else begin
            irq_out_primary_n_o.out <= 1'b0;
            irq_out_priority_n_o.out <= 1'b0;
            irq_out_primary_n_o.oe <= pending_any && !timer_run && !(|clear_bits) && !wd_again
                                      ? 1'b1 : (|set_bits && !timer_run && !(|clear_bits));
            irq_out_priority_n_o.oe <= |(((status & ~clear_bits) | set_bits) & `PRIORITY_MASK);
        end
    end

    // ------------------------------------------------------------
    // Receive pins
    // ------------------------------------------------------------
    // Bus wake-up flags hold the matching receive output low.
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            can_rx_out_o <= 1'b1;
            lin_a_rx_out_o <= 1'b1;
            lin_b_rx_out_o <= 1'b1;
        end else begin
            can_rx_out_o <= can_rx_i && !status[`SRC_CAN_WAKE];
            lin_a_rx_out_o <= lin_a_rx_i && !status[`SRC_LIN_A_WAKE];
            lin_b_rx_out_o <= lin_b_rx_i && !status[`SRC_LIN_B_WAKE];
        end
    end

    // ------------------------------------------------------------
    // Mode control
    // ------------------------------------------------------------
    // Sleep guard, wake-up and watchdog reset decisions.
    always_comb begin
        next_mode = mode;
        case (mode)
            irq_wake_pkg::MODE_NORMAL: begin
                if (wd_again) begin
                    next_mode = irq_wake_pkg::MODE_RESET;
                end else if (sleep_cmd) begin
                    if ((enable & `REGULAR_MASK) == '0) begin
                        next_mode = irq_wake_pkg::MODE_RESET;
                    end else if (pending_any) begin
                        next_mode = irq_wake_pkg::MODE_RESET;
                    end else begin
                        next_mode = irq_wake_pkg::MODE_SLEEP;
                    end
                end
            end
            irq_wake_pkg::MODE_SLEEP: begin
                if (pending_any) begin
                    next_mode = irq_wake_pkg::MODE_RESET;
                end
            end
            irq_wake_pkg::MODE_RESET: begin
                if (hold_cnt == 8'(`RESET_HOLD_CYC - 1)) begin
                    next_mode = irq_wake_pkg::MODE_NORMAL;
                end
            end
            default: next_mode = irq_wake_pkg::MODE_RESET;
        endcase
    end

    // Mode register; a fresh reset starts in Reset mode.
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mode <= irq_wake_pkg::MODE_RESET;
        end else begin
            mode <= next_mode;
        end
    end

    // Counts the length of the Reset mode pulse.
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            hold_cnt <= '0;
        end else if (mode == irq_wake_pkg::MODE_RESET) begin
            hold_cnt <= hold_cnt + 8'h01;
        end else begin
            hold_cnt <= '0;
        end
    end

    assign chip_reset_out_n_o = (mode == irq_wake_pkg::MODE_NORMAL);
    assign op_mode_o = mode;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);

    a_event_sets_status: assert property (set_bits[`SRC_WATCHDOG] |=> status[`SRC_WATCHDOG])
        else $error("Watchdog event did not set its status bit.");
    a_clear_one_bit: assert property ((wr_status && bus_i.wdata[`SRC_OVERTEMP]
        && !set_bits[`SRC_OVERTEMP] && status[`SRC_OVERTEMP])
        |=> !status[`SRC_OVERTEMP])
        else $error("Write of one did not clear status bit.");
    a_status_sticky: assert property ((status[1] && !clear_bits[1]) |=> status[1])
        else $error("Status bit dropped without a clear.");
    a_timer_start: assert property (((|clear_bits) && chip_reset_out_n_o)
        |=> delay_cnt == IRQ_DELAY_CYC)
        else $error("Delay timer did not start on a clear.");
    a_primary_hold: assert property (timer_run |=> !irq_out_primary_n_o.oe)
        else $error("Primary request driven while timer runs.");
    a_primary_expiry: assert property ((!timer_run && pending_any && !(|clear_bits) && !wd_again)
        |=> irq_out_primary_n_o.oe)
        else $error("Primary request not driven after expiry.");
    a_timer_stop: assert property (!chip_reset_out_n_o |=> delay_cnt == '0)
        else $error("Delay timer kept running in reset.");
    a_priority_fast: assert property (set_bits[`SRC_OVERTEMP] |=> irq_out_priority_n_o.oe)
        else $error("Priority request late.");
    a_release_clear: assert property (!pending_any && !(|set_bits)
        |=> !irq_out_primary_n_o.oe && !irq_out_priority_n_o.oe)
        else $error("Request driven with nothing pending.");
    a_never_high: assert property (!irq_out_primary_n_o.out && !irq_out_priority_n_o.out)
        else $error("Open-drain output driven high.");
    a_sleep_guard: assert property ((mode == irq_wake_pkg::MODE_NORMAL && sleep_cmd && !wd_again
        && (pending_any || (enable & `REGULAR_MASK) == '0))
        |=> mode == irq_wake_pkg::MODE_RESET)
        else $error("Sleep entered while guarded.");
    a_sleep_wake: assert property ((mode == irq_wake_pkg::MODE_SLEEP && pending_any)
        |=> mode == irq_wake_pkg::MODE_RESET ##1 !chip_reset_out_n_o)
        else $error("Sleep did not wake on interrupt.");
    a_rx_hold: assert property (status[`SRC_CAN_WAKE] |=> !can_rx_out_o)
        else $error("CAN receive pin not held low.");
    a_wd_reset: assert property ((wd_again && mode == irq_wake_pkg::MODE_NORMAL)
        |=> mode == irq_wake_pkg::MODE_RESET)
        else $error("Repeated watchdog overflow did not reset.");

    c_sleep_enter: cover property (mode == irq_wake_pkg::MODE_SLEEP);
    c_wake_reset: cover property (mode == irq_wake_pkg::MODE_SLEEP ##1 mode == irq_wake_pkg::MODE_RESET);
    c_delay_expire: cover property (timer_run ##1 !timer_run && pending_any);
    c_set_clear_same: cover property ((|(set_bits & clear_bits)));

endmodule : interrupt_wake_controller

`default_nettype wire

//--- src/irq_wake_consts.svh
// What this block does
// - Enabled event pulls primary request low; priority too if critical
// - Interrupt during Sleep wakes into Reset mode
// - Wake-ups are interrupts; interrupts wake chip
// - Request outputs open-drain, active low only
// - Priority output serves critical sources only
// - One pending status bit per source
// - Global status flags pending categories
// - Write one clears status; zero no effect
// - Priority output releases only when its bits clear
// - Clearing bits releases primary, starts timer
// - Timer running: capture events, primary released
// - Timer expiry drives primary if pending
// - Status readable and clearable at all times
// - Chip reset low stops delay timer
// - Timer never affects priority output
// - Sources classed regular or diagnostic
// - Sleep with no regular enables resets
// - Sleep command while pending goes Reset
// - Four sources permanently enabled
// - Bus wake-up holds receive pin low
// - Repeated watchdog overflow while pending resets
`ifndef IRQ_WAKE_CONSTS_SVH
`define IRQ_WAKE_CONSTS_SVH

`define NUM_SRC 21
// Source bit positions.
`define SRC_CAN_FAIL 0
`define SRC_CAN_WAKE 1
`define SRC_CAN_SILENCE 2
`define SRC_LIN_A_WAKE 3
`define SRC_LIN_B_WAKE 4
`define SRC_WATCHDOG 5
`define SRC_OVERTEMP 6
`define SRC_FRAME_ERR 7
`define SRC_POWER_ON 8
`define SRC_SPI_FAIL 9
`define SRC_V1_UNDER 10
`define SRC_V2_UNDER 11
`define SRC_V2_OVER 12
`define SRC_BAT_UNDER 13
`define SRC_BAT_OVER 14
`define SRC_OVSD 15
`define SRC_SMPS 16
`define SRC_IO_OPEN 17
`define SRC_IO_SHORT 18
`define SRC_IO_RISE 19
`define SRC_IO_FALL 20
// Source class masks.
`define REGULAR_MASK 21'h18001A
`define ALWAYS_ON_MASK 21'h0081A0
`define PRIORITY_MASK 21'h01E440
`define CAT_SYSTEM_MASK 21'h000360
`define CAT_SUPPLY_MASK 21'h01FC00
`define CAT_XCVR_MASK 21'h00009F
`define CAT_BANK0_MASK 21'h1E0000
`define CAT_BANK1_MASK 21'h000000
// Register offsets and reset values.
`define ADDR_STATUS 8'h00
`define ADDR_ENABLE 8'h04
`define ADDR_GLOBAL 8'h08
`define ADDR_MODE 8'h0C
`define ENABLE_RESET 21'h000000
// Mode command codes.
`define MODE_CMD_SLEEP 3'h1
`define MODE_CMD_NORMAL 3'h7
// Timing.
`define IRQ_DELAY_TIMEOUT_US 1000
`define CLK_MHZ 100
`define IRQ_DELAY_CYC (`IRQ_DELAY_TIMEOUT_US * `CLK_MHZ)
`define RESET_HOLD_NS 200
`define RESET_HOLD_CYC ((`RESET_HOLD_NS * `CLK_MHZ) / 1000)

`endif

//--- src/irq_wake_pkg.sv
package irq_wake_pkg;

    // Register port request from software.
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

    // Chip operating mode, one-hot.
    typedef enum logic [2:0] {
        MODE_NORMAL = 3'b001,
        MODE_SLEEP = 3'b010,
        MODE_RESET = 3'b100
    } op_mode_t;

    // Open-drain pin drive pair.
    typedef struct packed {
        logic out;
        logic oe;
    } od_pin_t;

endpackage : irq_wake_pkg

//--- tb/host_pullup.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// Host side of the request lines
// ----------------------------------------
module host_pullup (
    input wire irq_wake_pkg::od_pin_t primary_i,
    input wire irq_wake_pkg::od_pin_t priority_i,
    output logic primary_level_o,
    output logic priority_level_o
);
    // The pull-ups hold each line high unless its driver enables the low drive.
    assign primary_level_o = primary_i.oe ? primary_i.out : 1'b1;
    assign priority_level_o = priority_i.oe ? priority_i.out : 1'b1;
endmodule : host_pullup

`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "irq_wake_consts.svh"

module testbench;
    localparam int DLY = 20;
    logic mclk_i = 1'b0;
    logic nrst_i = 1'b0;
    irq_wake_pkg::bus_req_t bus = '0;
    logic [20:0] ev = '0;
    logic wd_ovf = 1'b0;
    logic [31:0] rdata;
    logic [31:0] v;
    irq_wake_pkg::od_pin_t prim;
    irq_wake_pkg::od_pin_t pri;
    irq_wake_pkg::op_mode_t mode;
    logic rx_c, rx_a, rx_b, rst_n, pl, ql;
    int bad_count = 0;
    int checked = 0;
    int n;
    int wk [3] = '{`SRC_CAN_WAKE, `SRC_LIN_A_WAKE, `SRC_LIN_B_WAKE};

    interrupt_wake_controller #(.IRQ_DELAY_CYC(DLY)) dut (.mclk_i(mclk_i), .nrst_i(nrst_i),
        .bus_i(bus), .rdata_o(rdata), .event_i(ev), .watchdog_overflow_i(wd_ovf),
        .can_rx_i(1'b1), .lin_a_rx_i(1'b1), .lin_b_rx_i(1'b1),
        .irq_out_primary_n_o(prim), .irq_out_priority_n_o(pri), .can_rx_out_o(rx_c),
        .lin_a_rx_out_o(rx_a), .lin_b_rx_out_o(rx_b), .chip_reset_out_n_o(rst_n),
        .op_mode_o(mode));
    host_pullup host (.primary_i(prim), .priority_i(pri), .primary_level_o(pl),
        .priority_level_o(ql));

    // The clock toggles every 5 ns.
    initial begin
        forever #5 mclk_i = ~mclk_i;
    end

    // ----------------------------------------
    // Access and comparison tasks
    // ----------------------------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk_i);
        bus <= '0;
        #1;
    endtask : wr

    // Read data stand only in the cycle after the strobe is taken.
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk_i);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge mclk_i);
        bus <= '0;
        #1;
        d = rdata;
    endtask : rd

    task automatic pulse(input int k);
        @(posedge mclk_i);
        ev <= 21'h1 << k;
        @(posedge mclk_i);
        ev <= '0;
        #1;
    endtask : pulse

    task automatic wait_mode(input irq_wake_pkg::op_mode_t m, input int lim);
        for (n = 0; n < lim && mode !== m; n++) begin
            @(posedge mclk_i);
            #1;
        end
        chk("mode", 32'(m), 32'(mode));
        if (mode !== m) begin
            stop_test();
        end
    endtask : wait_mode

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge mclk_i);
        nrst_i <= 1'b1;
        #1;
        chk("reset_out_n", 32'h0, 32'(rst_n));
        chk("lines", 32'h3, {pl, ql});
        wait_mode(irq_wake_pkg::MODE_NORMAL, 40);
        rd(`ADDR_ENABLE, v);
        chk("enable", `ALWAYS_ON_MASK, v);
        pulse(`SRC_OVERTEMP);
        rd(`ADDR_STATUS, v);
        chk("status", 32'h0, v);
        pulse(`SRC_WATCHDOG);
        chk("levels", 32'h1, {pl, ql});
        rd(`ADDR_GLOBAL, v);
        chk("global", 32'h1, v);
        @(posedge mclk_i);
        wd_ovf <= 1'b1;
        @(posedge mclk_i);
        wd_ovf <= 1'b0;
        wait_mode(irq_wake_pkg::MODE_RESET, 3);
        wait_mode(irq_wake_pkg::MODE_NORMAL, 40);
        wr(`ADDR_ENABLE, 32'h1FFFFF);
        wr(`ADDR_STATUS, 32'h0);
        rd(`ADDR_STATUS, v);
        chk("status", 32'h20, v);
        pulse(`SRC_OVERTEMP);
        chk("levels", 32'h0, {pl, ql});
        wr(`ADDR_STATUS, 32'h60);
        chk("levels", 32'h3, {pl, ql});
        pulse(`SRC_BAT_UNDER);
        chk("levels", 32'h2, {pl, ql});
        rd(`ADDR_STATUS, v);
        chk("status", 32'h2000, v);
        rd(`ADDR_GLOBAL, v);
        chk("global", 32'h2, v);
        for (n = 6; n < DLY + 10 && pl === 1'b1; n++) begin
            @(posedge mclk_i);
            #1;
        end
        chk("delay_ok", 32'h1, 32'(n >= DLY - 2 && n <= DLY + 2));
        pulse(`SRC_OVERTEMP);
        wr(`ADDR_STATUS, 32'h2000);
        chk("priority", 32'h0, 32'(ql));
        wr(`ADDR_STATUS, 32'h40);
        chk("levels", 32'h3, {pl, ql});
        foreach (wk[i]) begin
            pulse(wk[i]);
            // The receive outputs follow the status flag one clock later.
            @(posedge mclk_i);
            #1;
            chk("rx_outs", 32'h7 & ~(32'h4 >> i), {rx_c, rx_a, rx_b});
            rd(`ADDR_STATUS, v);
            chk("status", 32'h1 << wk[i], v);
            wr(`ADDR_STATUS, 32'h1 << wk[i]);
            @(posedge mclk_i);
            #1;
            chk("rx_outs", 32'h7, {rx_c, rx_a, rx_b});
        end
        wr(`ADDR_ENABLE, 32'h1FFFFF & ~`REGULAR_MASK);
        wr(`ADDR_MODE, `MODE_CMD_SLEEP);
        wait_mode(irq_wake_pkg::MODE_RESET, 3);
        wait_mode(irq_wake_pkg::MODE_NORMAL, 40);
        wr(`ADDR_ENABLE, 32'h1FFFFF);
        pulse(`SRC_SPI_FAIL);
        wr(`ADDR_MODE, `MODE_CMD_SLEEP);
        wait_mode(irq_wake_pkg::MODE_RESET, 3);
        wait_mode(irq_wake_pkg::MODE_NORMAL, 40);
        wr(`ADDR_STATUS, 32'h200);
        wr(`ADDR_MODE, `MODE_CMD_SLEEP);
        wait_mode(irq_wake_pkg::MODE_SLEEP, 3);
        chk("reset_out_n", 32'h0, 32'(rst_n));
        pulse(`SRC_IO_RISE);
        chk("primary", 32'h0, 32'(pl));
        wait_mode(irq_wake_pkg::MODE_RESET, 3);
        stop_test();
    end
endmodule : testbench

`default_nettype wire
